// *** verilog/uaef_flow.sv ***
// uaef_flow.sv: enhanced flow control for one uart channel: automatic
// request-to-send, automatic clear-to-send gating, special character
// detect and the write guard on upper control fields, behind apb.
// assumes: rx fifo, transmitter and baud logic sit outside on clock;
// clear_to_send_in_n is an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none
`include "uaef_regs.svh"

////////////////////////////////////////////////////////////////////////
module uaef_flow #(
  parameter int LVL_W = 9
) (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire uaef_pkg::uaef_apb_req_t apb_req,
  output var  uaef_pkg::uaef_apb_rsp_t apb_rsp,
  input  wire uaef_pkg::uaef_char_t    rx_in,
  input  wire logic [LVL_W-1:0]       rx_level,
  output var  uaef_pkg::uaef_char_t    rx_fifo_wr,
  input  wire logic                   clear_to_send_in_n,
  output var  logic                   request_to_send_out_n,
  input  wire logic                   tx_start_req,
  output var  logic                   tx_start,
  output var  logic                   tx_halted,
  output var  uaef_pkg::uaef_ctrl_t    ctrl,
  output var  logic                   irq
);

  // the level must cover an 8-bit threshold and stay modest
  if (LVL_W < 8 || LVL_W > 16) begin : g_bad_width
    $error("uaef_flow: LVL_W must lie in 8..16");
  end

  ////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] efc_reg;
  logic [7:0] ier_reg;
  logic [7:0] fcr_reg;
  logic [7:0] mcr_reg;
  logic [7:0] upper_reg;
  logic [7:0] lower_reg;
  logic [7:0] ssc_reg;
  logic [7:0] ist_reg;
  logic [7:0] imask_reg;
  logic [7:0] ist_next;
  logic [7:0] ier_next;
  logic [7:0] fcr_next;
  logic [7:0] mcr_next;
  logic       rts_prev_reg;
  logic       halt_prev_reg;

  ////////////////////////////////////////////////////////////////////
  // apb decode

  logic        acc;
  logic        wr;
  logic [7:0]  wd;
  logic        hit_efc;
  logic        hit_ier;
  logic        hit_fcr;
  logic        hit_mcr;
  logic        hit_upper;
  logic        hit_lower;
  logic        hit_ssc;
  logic        hit_ist;
  logic        hit_imask;
  logic        hit_state;
  logic        hit_any;
  logic        enh_on;
  logic [7:0]  state_view;
  logic [31:0] rd_byte;

  // access phase; the slave never waits, so every access ends here
  assign acc = apb_req.psel & apb_req.penable;
  assign wr  = acc & apb_req.pwrite;
  assign wd  = apb_req.pwdata[7:0];

  assign hit_efc   = apb_req.paddr == `UAEF_OFF_EFC;
  assign hit_ier   = apb_req.paddr == `UAEF_OFF_IER;
  assign hit_fcr   = apb_req.paddr == `UAEF_OFF_FCR;
  assign hit_mcr   = apb_req.paddr == `UAEF_OFF_MCR;
  assign hit_upper = apb_req.paddr == `UAEF_OFF_UPPER;
  assign hit_lower = apb_req.paddr == `UAEF_OFF_LOWER;
  assign hit_ssc   = apb_req.paddr == `UAEF_OFF_SSC;
  assign hit_ist   = apb_req.paddr == `UAEF_OFF_IST;
  assign hit_imask = apb_req.paddr == `UAEF_OFF_IMASK;
  assign hit_state = apb_req.paddr == `UAEF_OFF_STATE;
  assign hit_any   = hit_efc | hit_ier | hit_fcr | hit_mcr |
                     hit_upper | hit_lower | hit_ssc | hit_ist |
                     hit_imask | hit_state;

  // read mux; unmapped reads return zero with an error
  assign rd_byte = {24'h000000,
                    hit_efc   ? efc_reg   :
                    hit_ier   ? ier_reg   :
                    hit_fcr   ? fcr_reg   :
                    hit_mcr   ? mcr_reg   :
                    hit_upper ? upper_reg :
                    hit_lower ? lower_reg :
                    hit_ssc   ? ssc_reg   :
                    hit_ist   ? ist_reg   :
                    hit_imask ? imask_reg :
                    hit_state ? state_view : 8'h00};

  assign apb_rsp.prdata  = rd_byte;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~hit_any;

  ////////////////////////////////////////////////////////////////////
  // guarded writes: protected bits keep their value unless enabled

  assign enh_on = efc_reg[`UAEF_EFC_ENH];

  assign ier_next = (wd & ~`UAEF_IER_PROT) |
                    ((enh_on ? wd : ier_reg) & `UAEF_IER_PROT);
  assign fcr_next = (wd & ~`UAEF_FCR_PROT) |
                    ((enh_on ? wd : fcr_reg) & `UAEF_FCR_PROT);
  assign mcr_next = (wd & ~`UAEF_MCR_PROT) |
                    ((enh_on ? wd : mcr_reg) & `UAEF_MCR_PROT);

  // feature bits all come up off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)              efc_reg <= `UAEF_RST_BYTE;
    else if (wr && hit_efc) efc_reg <= wd;
  end

  // guarded control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ier_reg <= `UAEF_RST_BYTE;
      fcr_reg <= `UAEF_RST_BYTE;
      mcr_reg <= `UAEF_RST_BYTE;
    end else begin
      if (wr && hit_ier) ier_reg <= ier_next;
      if (wr && hit_fcr) fcr_reg <= fcr_next;
      if (wr && hit_mcr) mcr_reg <= mcr_next;
    end
  end

  // thresholds, stop character and interrupt mask
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      upper_reg <= `UAEF_RST_UPPER;
      lower_reg <= `UAEF_RST_LOWER;
      ssc_reg   <= `UAEF_RST_BYTE;
      imask_reg <= `UAEF_RST_BYTE;
    end else begin
      if (wr && hit_upper) upper_reg <= wd;
      if (wr && hit_lower) lower_reg <= wd;
      if (wr && hit_ssc)   ssc_reg   <= wd;
      if (wr && hit_imask) imask_reg <= wd;
    end
  end

  assign ctrl.int_en    = ier_reg;
  assign ctrl.fifo_ctl  = fcr_reg;
  assign ctrl.modem_ctl = mcr_reg;

  ////////////////////////////////////////////////////////////////////
  // automatic request-to-send

  // lower threshold above upper gives no hold band; software's care
  uaef_rts_hyst #(
    .LVL_W (LVL_W)
  ) u_rts (
    .clock    (clock),
    .rstn     (rstn),
    .auto_en  (efc_reg[`UAEF_EFC_RTS]),
    .manual_n (~mcr_reg[`UAEF_MCR_RTS]),
    .level    (rx_level),
    .upper    (upper_reg),
    .lower    (lower_reg),
    .rts_n    (request_to_send_out_n)
  );

  ////////////////////////////////////////////////////////////////////
  // automatic clear-to-send

  logic cts_s;

  uaef_sync #(
    .INIT (1'b1)
  ) u_cts_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (clear_to_send_in_n),
    .q     (cts_s)
  );

  // gating acts on character starts, so a frame in flight completes
  assign tx_halted = efc_reg[`UAEF_EFC_CTS] & cts_s;
  assign tx_start  = tx_start_req & ~tx_halted;

  ////////////////////////////////////////////////////////////////////
  // special character detect and receive pass-through

  logic spc_hit;

  assign spc_hit = rx_in.valid & efc_reg[`UAEF_EFC_SPC] &
                   (rx_in.data == ssc_reg);

  // every character goes on to the fifo, match or not
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rx_fifo_wr <= '0;
    else       rx_fifo_wr <= rx_in;
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status and interrupt; a new event beats a same-cycle clear

  logic [7:0] ev;
  logic [7:0] clr;

  assign ev = (8'h01 << `UAEF_IST_SPC) & {8{spc_hit}} |
              (8'h01 << `UAEF_IST_RTS) &
                {8{request_to_send_out_n & ~rts_prev_reg}} |
              (8'h01 << `UAEF_IST_CTS) & {8{tx_halted & ~halt_prev_reg}};
  assign clr      = (wr && hit_ist) ? wd : 8'h00;
  assign ist_next = (ist_reg & ~clr) | ev;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ist_reg       <= `UAEF_RST_BYTE;
      rts_prev_reg  <= 1'b1;
      halt_prev_reg <= 1'b0;
    end else begin
      ist_reg       <= ist_next;
      rts_prev_reg  <= request_to_send_out_n;
      halt_prev_reg <= tx_halted;
    end
  end

  assign irq = |(ist_reg & imask_reg);

  // live view of the flow-control lines
  assign state_view = {5'h00, tx_halted, cts_s, request_to_send_out_n};

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_rts_goes_high: assert property (
    efc_reg[`UAEF_EFC_RTS] && rx_level > LVL_W'(upper_reg)
      |=> request_to_send_out_n)
    else $error("rts not raised above upper threshold");

  a_rts_goes_low: assert property (
    efc_reg[`UAEF_EFC_RTS] && rx_level < LVL_W'(lower_reg)
      && rx_level <= LVL_W'(upper_reg)
      |=> !request_to_send_out_n)
    else $error("rts not lowered below lower threshold");

  a_rts_band_hold: assert property (
    efc_reg[`UAEF_EFC_RTS] && rx_level >= LVL_W'(lower_reg)
      && rx_level <= LVL_W'(upper_reg)
      |=> $stable(request_to_send_out_n))
    else $error("rts moved inside the hold band");

  a_efc_reset_off: assert property (
    !$past(rstn) |-> efc_reg[7:5] == 3'h0 && !tx_halted)
    else $error("feature bits not clear after reset");

  a_spc_flag_set: assert property (
    rx_in.valid && efc_reg[`UAEF_EFC_SPC] && rx_in.data == ssc_reg
      |=> ist_reg[`UAEF_IST_SPC] && rx_fifo_wr.valid)
    else $error("special match not flagged");

  a_rx_stored: assert property (
    rx_in.valid |=> rx_fifo_wr.valid && rx_fifo_wr.data == $past(rx_in.data))
    else $error("received character not passed on");

  a_guard_blocks: assert property (
    wr && hit_mcr && !enh_on
      |=> mcr_reg[7:5] == $past(mcr_reg[7:5]))
    else $error("guarded bits written while guard off");

  a_guard_opens: assert property (
    wr && hit_ier && enh_on |=> ier_reg == $past(wd))
    else $error("guarded bits refused while guard on");

  a_cts_halts_tx: assert property (
    efc_reg[`UAEF_EFC_CTS] && cts_s |-> !tx_start)
    else $error("transmit started while cts high");

  a_cts_resumes: assert property (
    tx_start_req && (!cts_s || !efc_reg[`UAEF_EFC_CTS]) |-> tx_start)
    else $error("transmit held while clear to send");

  // guard, flag, manual-mode and interrupt-mask checks

  a_guard_ier_block: assert property (
    wr && hit_ier && !enh_on
      |=> ier_reg[7:4] == $past(ier_reg[7:4]))
    else $error("guarded interrupt-enable bits written while guard off");

  a_guard_fcr_block: assert property (
    wr && hit_fcr && !enh_on
      |=> fcr_reg[5:4] == $past(fcr_reg[5:4]))
    else $error("guarded fifo-control bits written while guard off");

  a_guard_mcr_opens: assert property (
    wr && hit_mcr && enh_on |=> mcr_reg == $past(wd))
    else $error("modem-control write refused while guard on");

  a_spc_off_quiet: assert property (
    !(rx_in.valid && efc_reg[`UAEF_EFC_SPC]) |=> !$rose(ist_reg[`UAEF_IST_SPC]))
    else $error("special flag set with detection off");

  a_rts_manual: assert property (
    !efc_reg[`UAEF_EFC_RTS]
      |=> request_to_send_out_n == !$past(mcr_reg[`UAEF_MCR_RTS]))
    else $error("rts not following manual control");

  a_cts_event: assert property (
    tx_halted && !halt_prev_reg |=> ist_reg[`UAEF_IST_CTS])
    else $error("start of halt not flagged");

  a_irq_masked: assert property (
    imask_reg == 8'h00 |-> !irq)
    else $error("interrupt raised while fully masked");

endmodule // uaef_flow

`default_nettype wire

// *** verilog/uaef_regs.svh ***
// uaef_regs.svh: register offsets, field positions and reset values
// for the enhanced flow-control block.
// assumes: included by bare name; defines only.
`ifndef UAEF_REGS_SVH
`define UAEF_REGS_SVH

// byte offsets on the apb bus, one aligned word each
`define UAEF_OFF_EFC   8'h00
`define UAEF_OFF_IER   8'h04
`define UAEF_OFF_FCR   8'h08
`define UAEF_OFF_MCR   8'h0c
`define UAEF_OFF_UPPER 8'h10
`define UAEF_OFF_LOWER 8'h14
`define UAEF_OFF_SSC   8'h18
`define UAEF_OFF_IST   8'h1c
`define UAEF_OFF_IMASK 8'h20
`define UAEF_OFF_STATE 8'h24

// enhanced_feature_control fields
`define UAEF_EFC_CTS 7
`define UAEF_EFC_RTS 6
`define UAEF_EFC_SPC 5
`define UAEF_EFC_ENH 4

// fields guarded by the enhanced write enable, plus the unguarded manual rts bit
`define UAEF_IER_PROT 8'hf0
`define UAEF_FCR_PROT 8'h30
`define UAEF_MCR_PROT 8'he0
`define UAEF_MCR_RTS  1

// interrupt_status event bits
`define UAEF_IST_RTS 0
`define UAEF_IST_CTS 1
`define UAEF_IST_SPC 4

// reset values
`define UAEF_RST_BYTE  8'h00
`define UAEF_RST_UPPER 8'hf0
`define UAEF_RST_LOWER 8'h10

`endif

// *** verilog/uaef_pkg.sv ***
// uaef_pkg.sv: carrier types for the enhanced flow-control block.
// assumes: compiled before every module that uses it.
package uaef_pkg;

  // apb request from the master
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } uaef_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uaef_apb_rsp_t;

  // one received character with its strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uaef_char_t;

  // guarded control fields handed to the rest of the uart
  typedef struct packed {
    logic [7:0] int_en;
    logic [7:0] fifo_ctl;
    logic [7:0] modem_ctl;
  } uaef_ctrl_t;

endpackage

// *** verilog/uaef_sync.sv ***
// uaef_sync.sv: two-flop synchroniser for one level from a pin.
// assumes: d is asynchronous to clock; q is read by ordinary logic.
`timescale 1ns/1ps
`default_nettype none

module uaef_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic d,
  output var  logic q
);

  logic meta_reg;

  // first flop feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // uaef_sync

`default_nettype wire

// *** verilog/uaef_rts_hyst.sv ***
// uaef_rts_hyst.sv: request-to-send level with fill-level hysteresis.
// assumes: level and thresholds come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module uaef_rts_hyst #(
  parameter int LVL_W = 9
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             auto_en,
  input  wire logic             manual_n,
  input  wire logic [LVL_W-1:0] level,
  input  wire logic [7:0]       upper,
  input  wire logic [7:0]       lower,
  output var  logic             rts_n
);

  logic above;
  logic below;
  logic rts_next;

  // a narrower level would cut the 8-bit thresholds in the compare
  if (LVL_W < 8) begin : g_bad_width
    $error("uaef_rts_hyst: LVL_W must be at least 8");
  end

  // thresholds widened to the level width for compare
  assign above = level > LVL_W'(upper);
  assign below = level < LVL_W'(lower);
  // between the thresholds the old level holds
  assign rts_next = !auto_en ? manual_n :
                    above    ? 1'b1 :
                    below    ? 1'b0 : rts_n;

  // reset leaves the line deasserted (high)
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rts_n <= 1'b1;
    else       rts_n <= rts_next;
  end

endmodule // uaef_rts_hyst

`default_nettype wire

// *** testbench/uaef_remote.sv ***
// uaef_remote.sv: remote serial device on the far side of the flow lines.
// assumes: bench clock; characters handed over as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

module uaef_remote (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 rts_n,
  input  wire logic                 go,
  input  wire logic [7:0]           ch,
  input  wire logic                 hold_off,
  output var  uaef_pkg::uaef_char_t rx,
  output var  logic                 cts_n
);
  // a request is dropped while rts is high, so the fifo never overflows
  // idle data toggles so nothing can lean on a stale byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx <= 9'h000;
    end else begin
      rx.valid <= go & ~rts_n;
      rx.data  <= (go & ~rts_n) ? ch : ~rx.data;
    end
  end
  // cts pin is a plain level from the bench
  assign cts_n = hold_off;
endmodule // uaef_remote

`default_nettype wire

// *** testbench/test_uaef_flow.sv ***
// test_uaef_flow.sv: self-checking bench for the enhanced flow block.
// assumes: uaef_pkg compiled first; zero-wait apb slave.
`timescale 1ns/1ps
`default_nettype none
`include "uaef_regs.svh"

module test_uaef_flow;
  logic                    clock = 1'b0;
  logic                    rstn = 1'b0;
  uaef_pkg::uaef_apb_req_t apb_req = '0;
  uaef_pkg::uaef_apb_rsp_t apb_rsp;
  uaef_pkg::uaef_char_t    rx_in;
  uaef_pkg::uaef_char_t    rx_fifo_wr;
  uaef_pkg::uaef_ctrl_t    ctrl;
  logic [8:0]              rx_level = 9'h000;
  logic                    cts_n;
  logic                    rts_n;
  logic                    tx_req = 1'b0;
  logic                    tx_start;
  logic                    tx_halted;
  logic                    irq;
  logic                    go = 1'b0;
  logic [7:0]              ch = 8'h00;
  logic                    hold_off = 1'b0;
  int                      num_errors = 0;
  int                      checks = 0;
  int                      cycles = 0;
  logic [31:0]             rd;
  logic                    err;

  always #2.5 clock = ~clock;

  uaef_flow dut (.clock(clock), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rx_in(rx_in), .rx_level(rx_level), .rx_fifo_wr(rx_fifo_wr),
    .clear_to_send_in_n(cts_n), .request_to_send_out_n(rts_n),
    .tx_start_req(tx_req), .tx_start(tx_start), .tx_halted(tx_halted), .ctrl(ctrl), .irq(irq));
  uaef_remote remote (.clock(clock), .rstn(rstn), .rts_n(rts_n), .go(go), .ch(ch),
    .hold_off(hold_off), .rx(rx_in), .cts_n(cts_n));

  ////////////////////////////////////////////////////////////////////////
  // checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb master: setup, access, wait for pready, then release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge clock);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // remote sends one character; fifo strobe looked at in its one cycle
  task automatic send(input logic [7:0] c, input logic exp_v);
    go <= 1'b1;
    ch <= c;
    @(posedge clock);
    go <= 1'b0;
    wait_cyc(2);
    chk("fifo strobe", {31'h0, rx_fifo_wr.valid}, {31'h0, exp_v});
    if (exp_v) chk("fifo data", {24'h0, rx_fifo_wr.data}, {24'h0, c});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk("rts at reset", {31'h0, rts_n}, 32'h0000_0001);
    rdc("efc reset", `UAEF_OFF_EFC, 32'h0000_0000);
    rdc("upper reset", `UAEF_OFF_UPPER, 32'h0000_00f0);
    rdc("lower reset", `UAEF_OFF_LOWER, 32'h0000_0010);
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
  endtask

  task automatic t_guard();
    logic [7:0] offs [3] = '{`UAEF_OFF_IER, `UAEF_OFF_FCR, `UAEF_OFF_MCR};
    logic [7:0] prot [3] = '{`UAEF_IER_PROT, `UAEF_FCR_PROT, `UAEF_MCR_PROT};
    for (int i = 0; i < 3; i++) begin
      wr(`UAEF_OFF_EFC, 32'h0000_0000);
      wr(offs[i], 32'h0000_00ff);
      rdc("guarded off", offs[i], {24'h0, ~prot[i]});
      wr(`UAEF_OFF_EFC, 32'h0000_0010);
      wr(offs[i], 32'h0000_00ff);
      rdc("guarded on", offs[i], 32'h0000_00ff);
    end
    chk("ctrl out", {8'h00, ctrl}, 32'h00ff_ffff);
    wr(`UAEF_OFF_EFC, 32'h0000_0000);
    wr(`UAEF_OFF_MCR, 32'h0000_0000);
    rdc("mcr kept", `UAEF_OFF_MCR, 32'h0000_00e0);
  endtask

  task automatic t_rts();
    wr(`UAEF_OFF_UPPER, 32'h0000_0020);
    wr(`UAEF_OFF_LOWER, 32'h0000_0008);
    wr(`UAEF_OFF_EFC, 32'h0000_0040);
    wr(`UAEF_OFF_IMASK, 32'h0000_0001);
    wr(`UAEF_OFF_IST, 32'h0000_00ff);
    wait_cyc(3);
    chk("rts low start", {31'h0, rts_n}, 32'h0000_0000);
    rx_level <= 9'h020;
    wait_cyc(3);
    chk("rts at upper", {31'h0, rts_n}, 32'h0000_0000);
    rx_level <= 9'h021;
    wait_cyc(3);
    chk("rts above", {31'h0, rts_n}, 32'h0000_0001);
    chk("irq rts", {31'h0, irq}, 32'h0000_0001);
    send(8'h55, 1'b0);
    rx_level <= 9'h008;
    wait_cyc(3);
    chk("rts hold", {31'h0, rts_n}, 32'h0000_0001);
    rx_level <= 9'h007;
    wait_cyc(3);
    chk("rts below", {31'h0, rts_n}, 32'h0000_0000);
    wr(`UAEF_OFF_IMASK, 32'h0000_0000);
    wait_cyc(1);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(`UAEF_OFF_IST, 32'h0000_0001);
    rdc("ist cleared", `UAEF_OFF_IST, 32'h0000_0000);
  endtask

  task automatic t_special();
    wr(`UAEF_OFF_SSC, 32'h0000_0013);
    wr(`UAEF_OFF_IMASK, 32'h0000_0010);
    send(8'h13, 1'b1);
    chk("irq detect off", {31'h0, irq}, 32'h0000_0000);
    wr(`UAEF_OFF_EFC, 32'h0000_0060);
    send(8'h14, 1'b1);
    chk("irq no match", {31'h0, irq}, 32'h0000_0000);
    send(8'h13, 1'b1);
    chk("irq match", {31'h0, irq}, 32'h0000_0001);
    rdc("ist match", `UAEF_OFF_IST, 32'h0000_0010);
    wr(`UAEF_OFF_IST, 32'h0000_0010);
    wait_cyc(1);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_cts();
    tx_req <= 1'b1;
    hold_off <= 1'b1;
    wr(`UAEF_OFF_EFC, 32'h0000_0000);
    wait_cyc(3);
    chk("tx cts off", {31'h0, tx_start}, 32'h0000_0001);
    wr(`UAEF_OFF_EFC, 32'h0000_0080);
    wait_cyc(3);
    chk("tx halted", {31'h0, tx_start}, 32'h0000_0000);
    chk("halted out", {31'h0, tx_halted}, 32'h0000_0001);
    // manual rts with modem bit 1 clear has raised rts, so bit 0 is set too
    rdc("state halted", `UAEF_OFF_STATE, 32'h0000_0007);
    rdc("ist cts", `UAEF_OFF_IST, 32'h0000_0003);
    hold_off <= 1'b0;
    wait_cyc(4);
    chk("tx resumed", {31'h0, tx_start}, 32'h0000_0001);
    chk("resumed out", {31'h0, tx_halted}, 32'h0000_0000);
  endtask

  // mid-run reset must clear feature bits that were set
  task automatic t_rerst();
    hold_off <= 1'b1;
    wr(`UAEF_OFF_EFC, 32'h0000_00e0);
    wait_cyc(3);
    chk("halted pre", {31'h0, tx_halted}, 32'h0000_0001);
    rstn <= 1'b0;
    wait_cyc(2);
    rstn <= 1'b1;
    chk("rts rerst", {31'h0, rts_n}, 32'h0000_0001);
    chk("halted rerst", {31'h0, tx_halted}, 32'h0000_0000);
    rdc("efc rerst", `UAEF_OFF_EFC, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    wait_cyc(8);
    rstn <= 1'b1;
    t_reset();
    t_guard();
    t_rts();
    t_special();
    t_cts();
    t_rerst();
    give_verdict();
  end
endmodule // test_uaef_flow

`default_nettype wire
